/* hw/ofs_map.svh */
`ifndef OFS_MAP_SVH
`define OFS_MAP_SVH

// clock and time bases
`define OFS_CLK_PERIOD_NS 100
`define OFS_TICK_NS 1000000
`define OFS_RAMP_TICK_NS 1000

// undervoltage offset ranges, mV
`define OFS_UVF_OFS_MIN 13'h0020
`define OFS_UVF_OFS_MAX 13'h01C0
`define OFS_UVF_STEP 13'h0020
`define OFS_UVW_OFS_MIN 13'h0018
`define OFS_UVW_OFS_MAX 13'h01C0
`define OFS_UVW_STEP 13'h0008

// per-phase valley limit range, A
`define OFS_OCL_MIN 8'h11
`define OFS_OCL_MAX 8'h82
// channel current limit reset value, A
`define OFS_OCF_RST 10'h3FF

// temperature limit range, degC
`define OFS_OT_MIN 8'h5A
`define OFS_OT_MAX 8'hA0

// phase selector codes for the current limit write
`define OFS_PHASE_ALL 8'hFF
`define OFS_PHASE_ONE 8'h00

// load-line slope fraction bits (slope LSB = 1/8 mOhm)
`define OFS_SLOPE_FRAC 3

// status bit positions
`define OFS_ST_TON 0
`define OFS_ST_BND 1
`define OFS_ST_UVF 2
`define OFS_ST_UVW 3
`define OFS_ST_OCF 4
`define OFS_ST_OCW 5
`define OFS_ST_SHR 6
`define OFS_ST_OTF 7
`define OFS_ST_OTW 8
`define OFS_ST_W 9

// ignore-response bit positions
`define OFS_IGN_TON 0
`define OFS_IGN_UVF 1
`define OFS_IGN_OCF 2
`define OFS_IGN_OTF 3

// class bit positions
`define OFS_CL_SUM 0
`define OFS_CL_VOUT 1
`define OFS_CL_IOUT 2
`define OFS_CL_TEMP 3

// margin select codes
`define OFS_MRG_HIGH 2'h1
`define OFS_MRG_LOW 2'h2

`endif

/* hw/ofs_pkg.sv */
package ofs_pkg;

  typedef logic [12:0] ofs_mv_t;

  typedef enum logic [1:0] {
    OFS_TON_IDLE = 2'b00,
    OFS_TON_RUN = 2'b01,
    OFS_TON_DONE = 2'b10
  } ofs_ton_t;

  function automatic ofs_mv_t ofs_clamp_mv(input ofs_mv_t v, input ofs_mv_t lo,
                                           input ofs_mv_t hi);
    if (v < lo) begin
      return lo;
    end
    if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  // saturates at zero so limits never wrap to a huge value
  function automatic ofs_mv_t ofs_sub_sat(input ofs_mv_t a, input ofs_mv_t b);
    return (a > b) ? ofs_mv_t'(a - b) : '0;
  endfunction

endpackage

/* hw/ofs_target_ramp.sv */
`include "ofs_map.svh"

module ofs_target_ramp import ofs_pkg::*; (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // ramp control
  input wire logic step_en_i,
  input wire logic [7:0] step_i,
  input ofs_mv_t req_i,
  input ofs_mv_t min_i,
  input ofs_mv_t max_i,
  // results
  output ofs_mv_t target_o,
  output logic bound_o
);

  typedef struct packed {
    ofs_mv_t tgt;
    logic bound;
  } ofs_ramp_t;

  ofs_ramp_t st_r;
  ofs_ramp_t st_nxt;

  always_comb begin
    ofs_mv_t goal;
    ofs_mv_t stp;
    goal = ofs_clamp_mv(req_i, min_i, max_i);
    stp = {5'h00, step_i};
    st_nxt = st_r;
    st_nxt.bound = (req_i < min_i) || (req_i > max_i);
    if (step_en_i) begin
      if (st_r.tgt < goal) begin
        st_nxt.tgt = (goal - st_r.tgt > stp) ? ofs_mv_t'(st_r.tgt + stp) : goal;
      end else if (st_r.tgt > goal) begin
        st_nxt.tgt = (st_r.tgt - goal > stp) ? ofs_mv_t'(st_r.tgt - stp) : goal;
      end
    end
    // a bound moved under the target: snap rather than ramp out of range
    st_nxt.tgt = ofs_clamp_mv(st_nxt.tgt, min_i, max_i);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign target_o = st_r.tgt;
  assign bound_o = st_r.bound;

  AST_TARGET_IN_BOUNDS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!$past(rst_i) && $past(min_i) <= $past(max_i))
    |-> (target_o >= $past(min_i) && target_o <= $past(max_i)))
    else $error("target left its bounds");

  AST_BOUND_WARN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (req_i > max_i || req_i < min_i) |=> bound_o)
    else $error("bound warning missing for out-of-range request");

endmodule

/* hw/ofs_supervisor.sv */
`include "ofs_map.svh"

// Contract
// - time turn-on from first pulses; fault if deadline passes before output is high enough.
// - arm undervoltage fault detection at the first pwm pulses of the rise.
// - turn-on fault, unless ignored, tristates the rail's pwm; sets status, alert.
// - output target never ramps outside the min and max bounds.
// - out-of-bound request raises bound warning; target ramps and stops at bound.
// - channel overcurrent fault when summed phase current exceeds limit written with FFh.
// - withhold pwm from a phase above the valley limit; nothing else happens.
// - valley limit comes from the 00h selector write, held within 17 to 130 A.
// - summed current above warning limit sets status bits and alert.
// - overcurrent fault, unless ignored, tristates the rail's pwm; sets status, alert.
// - compare each phase with channel average; warn when deviation reaches threshold.
// - balance warning sets status and alert, conversion continues.
// - overheat fault when channel temperature exceeds limit held within 90 to 160.
// - overheat warning above its own limit sets status bits and alert.
// - overheat fault, unless ignored, tristates the rail's pwm; sets status, alert.
// - target changes keep stored undervoltage offsets; limits reported as target minus offsets.
// - undervoltage limit write stores (target minus limit) divided by loop scale.
// - fault offsets 32 to 448 mV step 32; warning 24 to 448 step 8.
module ofs_supervisor import ofs_pkg::*; #(
  parameter int NPH = 3,
  parameter int TICK_CYC = `OFS_TICK_NS / `OFS_CLK_PERIOD_NS,
  parameter int RAMP_CYC = `OFS_RAMP_TICK_NS / `OFS_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // channel enable and modulator pulses
  input wire logic [1:0] conv_en_i,
  input wire logic [1:0][NPH-1:0] pwm_req_i,
  // output target request
  input ofs_mv_t [1:0] target_cmd_i,
  input ofs_mv_t [1:0] margin_hi_i,
  input ofs_mv_t [1:0] margin_lo_i,
  input wire logic [1:0][1:0] margin_sel_i,
  input wire logic [1:0][7:0] trim_i,
  input ofs_mv_t [1:0] vmin_i,
  input ofs_mv_t [1:0] vmax_i,
  input wire logic [1:0][7:0] ramp_step_i,
  // undervoltage limit writes
  input wire logic [1:0] uvf_wr_i,
  input wire logic [1:0] uvw_wr_i,
  input ofs_mv_t uv_lim_val_i,
  input wire logic [1:0][1:0] scale_log2_i,
  // current limits and telemetry
  input wire logic [1:0] oc_lim_wr_i,
  input wire logic [7:0] oc_lim_phase_i,
  input wire logic [9:0] oc_lim_val_i,
  input wire logic [1:0][9:0] ocw_lim_i,
  input wire logic [1:0][7:0] share_thr_i,
  input wire logic [1:0][7:0] slope_i,
  input wire logic [1:0][NPH-1:0][7:0] iph_i,
  // temperature
  input wire logic [1:0][7:0] temp_i,
  input wire logic [1:0][7:0] otf_lim_i,
  input wire logic [1:0][7:0] otw_lim_i,
  // output sense and turn-on deadline (ms)
  input ofs_mv_t [1:0] vsense_i,
  input wire logic [1:0][15:0] ton_lim_i,
  // response and status control
  input wire logic [1:0][3:0] ign_i,
  input wire logic [1:0][`OFS_ST_W-1:0] mask_i,
  input wire logic [1:0][`OFS_ST_W-1:0] clr_i,
  // power stage pins
  output logic [1:0][NPH-1:0] pwm_o,
  output logic [1:0][NPH-1:0] pwm_oe_n_o,
  // target and reported limits
  output ofs_mv_t [1:0] target_o,
  output ofs_mv_t [1:0] uvf_rpt_o,
  output ofs_mv_t [1:0] uvw_rpt_o,
  // status
  output logic [1:0][`OFS_ST_W-1:0] stat_o,
  output logic [1:0][3:0] class_o,
  output logic host_alert_n_o
);

  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int RW = $clog2(RAMP_CYC + 1);

  typedef struct packed {
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic [RW-1:0] ramp_cnt;
    logic ramp_tick;
    logic [1:0][9:0] ocf_lim;
    logic [1:0][7:0] ocl_lim;
    logic [1:0][12:0] uvf_ofs;
    logic [1:0][12:0] uvw_ofs;
    ofs_ton_t [1:0] ton_st;
    logic [1:0][15:0] ton_cnt;
    logic [1:0] uv_arm;
    logic [1:0] shut;
    logic [1:0][`OFS_ST_W-1:0] stat;
    logic [1:0][3:0] cls;
    logic [1:0][NPH-1:0] pwm;
    logic [1:0][NPH-1:0] pwm_oe_n;
    logic [1:0][12:0] uvf_rpt;
    logic [1:0][12:0] uvw_rpt;
    logic alert_n;
  } ofs_state_t;

  ofs_state_t state_r;
  ofs_state_t state_nxt;
  ofs_mv_t [1:0] tgt_w;
  logic [1:0] bound_w;

  // load-line drop in mV, saturated to the voltage range
  function automatic ofs_mv_t drop_mv(input logic [7:0] slope, input logic [11:0] amp);
    logic [19:0] p;
    p = slope * amp;
    p = p >> `OFS_SLOPE_FRAC;
    return (|p[19:13]) ? 13'h1FFF : p[12:0];
  endfunction

  function automatic ofs_mv_t quant_ofs(input ofs_mv_t v, input ofs_mv_t lo, input ofs_mv_t hi,
                                        input ofs_mv_t step);
    ofs_mv_t c;
    c = ofs_clamp_mv(v, lo, hi);
    return c & ~ofs_mv_t'(step - 13'h0001);
  endfunction

  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic ofs_mv_t req_calc(input ofs_mv_t cmd, input ofs_mv_t hi, input ofs_mv_t lo,
                                       input logic [1:0] sel, input logic [7:0] trim);
    ofs_mv_t base;
    logic [7:0] mag;
    base = (sel == `OFS_MRG_HIGH) ? hi : ((sel == `OFS_MRG_LOW) ? lo : cmd);
    mag = 8'(~trim + 8'h01);
    return trim[7] ? ofs_sub_sat(base, {5'h00, mag}) : ofs_mv_t'(base + {5'h00, trim});
  endfunction

  for (genvar g = 0; g < 2; g++) begin : g_ramp
    ofs_target_ramp u_ramp (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .step_en_i(state_r.ramp_tick),
      .step_i(ramp_step_i[g]),
      .req_i(req_calc(target_cmd_i[g], margin_hi_i[g], margin_lo_i[g], margin_sel_i[g],
                      trim_i[g])),
      .min_i(vmin_i[g]),
      .max_i(vmax_i[g]),
      .target_o(tgt_w[g]),
      .bound_o(bound_w[g])
    );
  end

  always_comb begin
    logic [11:0] isum;
    logic [11:0] avg;
    logic [11:0] iph;
    logic [`OFS_ST_W-1:0] ev;
    logic kill;
    logic run;
    ofs_mv_t drop;
    ofs_mv_t vton;
    ofs_mv_t diff;
    logic alert;
    isum = '0;
    avg = '0;
    iph = '0;
    ev = '0;
    kill = 1'b0;
    run = 1'b0;
    drop = '0;
    vton = '0;
    diff = '0;
    alert = 1'b0;
    state_nxt = state_r;

    // one-cycle enables from the two dividers
    state_nxt.tick = 1'b0;
    if (state_r.tick_cnt == TW'(TICK_CYC - 1)) begin
      state_nxt.tick_cnt = '0;
      state_nxt.tick = 1'b1;
    end else begin
      state_nxt.tick_cnt = TW'(state_r.tick_cnt + 1'b1);
    end
    state_nxt.ramp_tick = 1'b0;
    if (state_r.ramp_cnt == RW'(RAMP_CYC - 1)) begin
      state_nxt.ramp_cnt = '0;
      state_nxt.ramp_tick = 1'b1;
    end else begin
      state_nxt.ramp_cnt = RW'(state_r.ramp_cnt + 1'b1);
    end

    for (int c = 0; c < 2; c++) begin
      isum = '0;
      for (int p = 0; p < NPH; p++) begin
        isum = 12'(isum + {4'h0, iph_i[c][p]});
      end
      avg = 12'(isum / NPH);
      ev = '0;

      // limit writes
      if (oc_lim_wr_i[c] && oc_lim_phase_i == `OFS_PHASE_ALL) begin
        state_nxt.ocf_lim[c] = oc_lim_val_i;
      end
      if (oc_lim_wr_i[c] && oc_lim_phase_i == `OFS_PHASE_ONE) begin
        // the 8-bit limit would wrap above 255 A, so saturate first
        state_nxt.ocl_lim[c] = clamp8((|oc_lim_val_i[9:8]) ? 8'hFF : oc_lim_val_i[7:0],
                                      `OFS_OCL_MIN, `OFS_OCL_MAX);
      end
      diff = ofs_sub_sat(tgt_w[c], uv_lim_val_i) >> scale_log2_i[c];
      if (uvf_wr_i[c]) begin
        state_nxt.uvf_ofs[c] = quant_ofs(diff, `OFS_UVF_OFS_MIN, `OFS_UVF_OFS_MAX,
                                         `OFS_UVF_STEP);
      end
      if (uvw_wr_i[c]) begin
        state_nxt.uvw_ofs[c] = quant_ofs(diff, `OFS_UVW_OFS_MIN, `OFS_UVW_OFS_MAX,
                                         `OFS_UVW_STEP);
      end
      // reported limits follow the live target, offsets stay put
      state_nxt.uvf_rpt[c] = ofs_sub_sat(tgt_w[c], state_nxt.uvf_ofs[c]);
      state_nxt.uvw_rpt[c] = ofs_sub_sat(tgt_w[c], state_nxt.uvw_ofs[c]);

      // undervoltage, armed from the first pulse of the rise
      state_nxt.uv_arm[c] = conv_en_i[c] && (state_r.uv_arm[c] || |pwm_req_i[c]);
      drop = drop_mv(slope_i[c], isum);
      ev[`OFS_ST_UVF] = state_r.uv_arm[c] &&
                        (vsense_i[c] < ofs_sub_sat(state_r.uvf_rpt[c], drop));
      ev[`OFS_ST_UVW] = state_r.uv_arm[c] &&
                        (vsense_i[c] < ofs_sub_sat(state_r.uvw_rpt[c], drop));

      // turn-on deadline, counted in ms ticks
      vton = ofs_sub_sat(state_r.uvf_rpt[c],
                         drop_mv(slope_i[c], {2'b00, state_r.ocf_lim[c]}));
      unique case (state_r.ton_st[c])
        OFS_TON_IDLE: begin
          state_nxt.ton_cnt[c] = '0;
          if (conv_en_i[c] && |pwm_req_i[c]) begin
            state_nxt.ton_st[c] = OFS_TON_RUN;
          end
        end
        OFS_TON_RUN: begin
          if (vsense_i[c] > vton) begin
            state_nxt.ton_st[c] = OFS_TON_DONE;
          end else if (state_r.ton_cnt[c] >= ton_lim_i[c]) begin
            ev[`OFS_ST_TON] = 1'b1;
            state_nxt.ton_st[c] = OFS_TON_DONE;
          end else if (state_r.tick) begin
            state_nxt.ton_cnt[c] = 16'(state_r.ton_cnt[c] + 1'b1);
          end
        end
        OFS_TON_DONE: begin
        end
        default: begin
          state_nxt.ton_st[c] = OFS_TON_IDLE;
        end
      endcase
      if (!conv_en_i[c]) begin
        state_nxt.ton_st[c] = OFS_TON_IDLE;
      end

      // bound, current and temperature conditions
      ev[`OFS_ST_BND] = bound_w[c];
      ev[`OFS_ST_OCF] = isum > {2'b00, state_r.ocf_lim[c]};
      ev[`OFS_ST_OCW] = isum > {2'b00, ocw_lim_i[c]};
      for (int p = 0; p < NPH; p++) begin
        iph = {4'h0, iph_i[c][p]};
        if ((iph >= avg && 12'(iph - avg) >= {4'h0, share_thr_i[c]}) ||
            (avg > iph && 12'(avg - iph) >= {4'h0, share_thr_i[c]})) begin
          ev[`OFS_ST_SHR] = 1'b1;
        end
      end
      ev[`OFS_ST_OTF] = temp_i[c] > clamp8(otf_lim_i[c], `OFS_OT_MIN, `OFS_OT_MAX);
      ev[`OFS_ST_OTW] = temp_i[c] > clamp8(otw_lim_i[c], `OFS_OT_MIN, `OFS_OT_MAX);

      // sticky status, a new event beats a clear in the same cycle
      state_nxt.stat[c] = (state_r.stat[c] & ~clr_i[c]) | ev;

      // warnings (incl. balance) never stop conversion
      kill = (ev[`OFS_ST_TON] && !ign_i[c][`OFS_IGN_TON]) ||
             (ev[`OFS_ST_UVF] && !ign_i[c][`OFS_IGN_UVF]) ||
             (ev[`OFS_ST_OCF] && !ign_i[c][`OFS_IGN_OCF]) ||
             (ev[`OFS_ST_OTF] && !ign_i[c][`OFS_IGN_OTF]);
      // latched off until the channel is disabled again
      state_nxt.shut[c] = conv_en_i[c] && (state_r.shut[c] || kill);
      run = conv_en_i[c] && !state_nxt.shut[c];
      for (int p = 0; p < NPH; p++) begin
        state_nxt.pwm[c][p] = run && pwm_req_i[c][p] &&
                              !(iph_i[c][p] > state_r.ocl_lim[c]);
        state_nxt.pwm_oe_n[c][p] = !run;
      end

      state_nxt.cls[c][`OFS_CL_SUM] = |state_nxt.stat[c];
      state_nxt.cls[c][`OFS_CL_VOUT] = state_nxt.stat[c][`OFS_ST_TON] ||
                                       state_nxt.stat[c][`OFS_ST_BND] ||
                                       state_nxt.stat[c][`OFS_ST_UVF] ||
                                       state_nxt.stat[c][`OFS_ST_UVW];
      state_nxt.cls[c][`OFS_CL_IOUT] = state_nxt.stat[c][`OFS_ST_OCF] ||
                                       state_nxt.stat[c][`OFS_ST_OCW] ||
                                       state_nxt.stat[c][`OFS_ST_SHR];
      state_nxt.cls[c][`OFS_CL_TEMP] = state_nxt.stat[c][`OFS_ST_OTF] ||
                                       state_nxt.stat[c][`OFS_ST_OTW];
      alert = alert || |(state_nxt.stat[c] & ~mask_i[c]);
    end
    state_nxt.alert_n = !alert;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= '0;
      state_r.ocf_lim <= {2{`OFS_OCF_RST}};
      state_r.ocl_lim <= {2{`OFS_OCL_MAX}};
      state_r.uvf_ofs <= {2{`OFS_UVF_OFS_MAX}};
      state_r.uvw_ofs <= {2{`OFS_UVW_OFS_MAX}};
      state_r.pwm_oe_n <= '1;
      state_r.alert_n <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pwm_o = state_r.pwm;
  assign pwm_oe_n_o = state_r.pwm_oe_n;
  assign target_o = tgt_w;
  assign uvf_rpt_o = state_r.uvf_rpt;
  assign uvw_rpt_o = state_r.uvw_rpt;
  assign stat_o = state_r.stat;
  assign class_o = state_r.cls;
  assign host_alert_n_o = state_r.alert_n;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ton_hit;
    $rose(stat_o[0][`OFS_ST_TON]) && $past(conv_en_i[0]) && !$past(ign_i[0][`OFS_IGN_TON]);
  endsequence

  sequence s_ocf_hit;
    conv_en_i[0] && !ign_i[0][`OFS_IGN_OCF] && !oc_lim_wr_i[0] &&
    ({4'h0, iph_i[0][0]} > {2'b00, state_r.ocf_lim[0]});
  endsequence

  AST_TON_EXPIRY: assert property ($rose(stat_o[0][`OFS_ST_TON]) |->
    $past(state_r.ton_st[0]) == OFS_TON_RUN && $past(state_r.ton_cnt[0]) >= $past(ton_lim_i[0]))
    else $error("turn-on fault without expired deadline");

  AST_UV_ARMED: assert property ($rose(stat_o[0][`OFS_ST_UVF]) |-> $past(state_r.uv_arm[0]))
    else $error("undervoltage fault while unarmed");

  AST_TON_TRISTATE: assert property (s_ton_hit |-> pwm_oe_n_o[0] == '1 && pwm_o[0] == '0)
    else $error("turn-on fault left pwm driven");

  AST_OCF_TRISTATE: assert property (s_ocf_hit |=> stat_o[0][`OFS_ST_OCF] &&
    pwm_oe_n_o[0] == '1 ##1 pwm_oe_n_o[0] == '1 || !conv_en_i[0])
    else $error("overcurrent fault did not tristate");

  AST_VALLEY: assert property (iph_i[0][0] > state_r.ocl_lim[0] |=> !pwm_o[0][0])
    else $error("pulse passed above valley limit");

  AST_OCL_RANGE: assert property (state_r.ocl_lim[0] >= `OFS_OCL_MIN &&
    state_r.ocl_lim[0] <= `OFS_OCL_MAX)
    else $error("valley limit out of range");

  AST_OT_FAULT: assert property (temp_i[0] > `OFS_OT_MAX |=> stat_o[0][`OFS_ST_OTF])
    else $error("overheat fault missed");

  AST_STICKY: assert property (stat_o[0][`OFS_ST_OCW] && !clr_i[0][`OFS_ST_OCW]
    |=> stat_o[0][`OFS_ST_OCW])
    else $error("status bit dropped without clear");

  AST_ALERT: assert property (|(stat_o[0] & ~$past(mask_i[0])) |-> !host_alert_n_o)
    else $error("alert not asserted for unmasked status");

endmodule

/* verification/ofs_stage_model.sv */
module ofs_stage_model import ofs_pkg::*; #(
  parameter int NPH = 3
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // scenario settings
  input wire logic [1:0][NPH-1:0][7:0] cur_i,
  input wire logic [1:0][7:0] deg_i,
  input wire logic [7:0] rise_i,
  // controller side
  input wire logic [1:0][NPH-1:0] pwm_i,
  input wire logic [1:0][NPH-1:0] pwm_oe_n_i,
  input ofs_mv_t [1:0] target_i,
  // telemetry back to the controller
  output logic [1:0][NPH-1:0][7:0] iph_o,
  output logic [1:0][7:0] temp_o,
  output ofs_mv_t [1:0] vsense_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // telemetry lags one cycle, as a real sense path would
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      iph_o <= '0;
      temp_o <= '0;
      vsense_o <= '0;
    end else begin
      iph_o <= cur_i;
      temp_o <= deg_i;
      for (int c = 0; c < 2; c++) begin
        // rail collapses once every stage is released
        if (&pwm_oe_n_i[c]) begin
          vsense_o[c] <= '0;
        end else if (|pwm_i[c]) begin
          vsense_o[c] <= (vsense_o[c] + rise_i < target_i[c]) ?
                         ofs_mv_t'(vsense_o[c] + rise_i) : target_i[c];
        end
      end
    end
  end
endmodule

/* verification/test_output_fault_supervisor.sv */
`include "ofs_map.svh"

module test_output_fault_supervisor import ofs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NPH = 3;

  typedef struct packed {
    logic [7:0] i0;
    logic [7:0] i1;
    logic [7:0] i2;
    logic [7:0] t;
    logic [3:0] ign;
    logic [8:0] st;
    logic [3:0] cl;
    logic sh;
  } ofs_row_t;

  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] conv_en_i = '0;
  logic [1:0][NPH-1:0] pwm_req_i = '1;
  ofs_mv_t [1:0] target_cmd_i = {2{13'h03E8}};
  ofs_mv_t [1:0] margin_hi_i = {2{13'h0514}};
  ofs_mv_t [1:0] margin_lo_i = {2{13'h012C}};
  logic [1:0][1:0] margin_sel_i = '0;
  logic [1:0][7:0] trim_i = '0;
  ofs_mv_t [1:0] vmin_i = {2{13'h01F4}};
  ofs_mv_t [1:0] vmax_i = {2{13'h04B0}};
  logic [1:0][7:0] ramp_step_i = {2{8'h64}};
  logic [1:0] uvf_wr_i = '0;
  logic [1:0] uvw_wr_i = '0;
  ofs_mv_t uv_lim_val_i = 13'h0000;
  logic [1:0][1:0] scale_log2_i = '0;
  logic [1:0] oc_lim_wr_i = '0;
  logic [7:0] oc_lim_phase_i = 8'hFF;
  logic [9:0] oc_lim_val_i = 10'h064;
  logic [1:0][9:0] ocw_lim_i = {2{10'h050}};
  logic [1:0][7:0] share_thr_i = {2{8'h14}};
  logic [1:0][7:0] slope_i = '0;
  logic [1:0][7:0] otf_lim_i = {2{8'h78}};
  logic [1:0][7:0] otw_lim_i = {2{8'h64}};
  logic [1:0][15:0] ton_lim_i = {2{16'h0003}};
  logic [1:0][3:0] ign_i = {2{4'h2}};
  logic [1:0][`OFS_ST_W-1:0] mask_i = '0;
  logic [1:0][`OFS_ST_W-1:0] clr_i = '0;
  logic [1:0][NPH-1:0][7:0] cur_i = '0;
  logic [1:0][7:0] deg_i = {2{8'h19}};
  logic [7:0] rise_i = 8'h64;
  logic [1:0][NPH-1:0][7:0] iph_i;
  logic [1:0][7:0] temp_i;
  ofs_mv_t [1:0] vsense_i;
  logic [1:0][NPH-1:0] pwm_o;
  logic [1:0][NPH-1:0] pwm_oe_n_o;
  ofs_mv_t [1:0] target_o;
  ofs_mv_t [1:0] uvf_rpt_o;
  ofs_mv_t [1:0] uvw_rpt_o;
  logic [1:0][`OFS_ST_W-1:0] stat_o;
  logic [1:0][3:0] class_o;
  logic host_alert_n_o;
  int n_mismatch = 0;
  int checks_done = 0;
  ofs_row_t rows [8];

  always #50 sys_clk_i = ~sys_clk_i;

  // short tick counts keep the run brief
  ofs_supervisor #(.NPH(NPH), .TICK_CYC(10), .RAMP_CYC(2)) ofs_supervisor_i (
    .sys_clk_i, .rst_i, .conv_en_i, .pwm_req_i, .target_cmd_i, .margin_hi_i,
    .margin_lo_i, .margin_sel_i, .trim_i, .vmin_i, .vmax_i, .ramp_step_i,
    .uvf_wr_i, .uvw_wr_i, .uv_lim_val_i, .scale_log2_i, .oc_lim_wr_i,
    .oc_lim_phase_i, .oc_lim_val_i, .ocw_lim_i, .share_thr_i, .slope_i, .iph_i,
    .temp_i, .otf_lim_i, .otw_lim_i, .vsense_i, .ton_lim_i, .ign_i, .mask_i,
    .clr_i, .pwm_o, .pwm_oe_n_o, .target_o, .uvf_rpt_o, .uvw_rpt_o, .stat_o,
    .class_o, .host_alert_n_o);

  ofs_stage_model #(.NPH(NPH)) ofs_stage_model_i (
    .sys_clk_i, .rst_i, .cur_i, .deg_i, .rise_i, .pwm_i(pwm_o),
    .pwm_oe_n_i(pwm_oe_n_o), .target_i(target_o), .iph_o(iph_i),
    .temp_o(temp_i), .vsense_o(vsense_i));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic pulse_clr();
    clr_i[0] = '1;
    cyc(1);
    clr_i[0] = '0;
  endtask

  task automatic wr_oc(input logic [7:0] ph, input logic [9:0] v);
    oc_lim_phase_i = ph;
    oc_lim_val_i = v;
    oc_lim_wr_i[0] = 1'b1;
    cyc(1);
    oc_lim_wr_i[0] = 1'b0;
    cyc(1);
  endtask

  task automatic wr_uv(input logic f, input ofs_mv_t v);
    uv_lim_val_i = v;
    uvf_wr_i[0] = f;
    uvw_wr_i[0] = !f;
    cyc(1);
    uvf_wr_i[0] = 1'b0;
    uvw_wr_i[0] = 1'b0;
    cyc(1);
  endtask

  // restart the rail so every row begins from a released fault latch;
  // a tripped rail collapses, so its undervoltage bits follow the fault
  task automatic run_row(input ofs_row_t r);
    conv_en_i[0] = 1'b0;
    ign_i[0] = r.ign;
    cur_i[0] = {3{8'h14}};
    deg_i[0] = 8'h19;
    cyc(3);
    conv_en_i[0] = 1'b1;
    cyc(20);
    pulse_clr();
    cur_i[0] = {r.i2, r.i1, r.i0};
    deg_i[0] = r.t;
    cyc(4);
    chk(stat_o[0], r.st);
    chk(class_o[0], r.cl);
    chk(pwm_oe_n_o[0], {3{r.sh}});
    chk(host_alert_n_o, r.st == 9'h000);
    if (!r.sh) begin
      chk(pwm_o[0], 3'h7);
    end
    $display("row done");
  endtask

  task automatic ramp_to(input ofs_mv_t cmd, input logic [1:0] sel, input logic [7:0] tr,
                         input ofs_mv_t exp, input logic bnd);
    logic out;
    out = 1'b0;
    target_cmd_i[0] = cmd;
    margin_sel_i[0] = sel;
    trim_i[0] = tr;
    repeat (60) begin
      cyc(1);
      out |= (target_o[0] < vmin_i[0]) || (target_o[0] > vmax_i[0]);
    end
    chk(out, 1'b0);
    chk(target_o[0], exp);
    pulse_clr();
    cyc(1);
    chk(stat_o[0][`OFS_ST_BND], bnd);
    $display("ramp done");
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    rows = '{'{8'h14, 8'h14, 8'h14, 8'h19, 4'h2, 9'h000, 4'h0, 1'b0},
             '{8'h1E, 8'h1E, 8'h1E, 8'h19, 4'h2, 9'h020, 4'h5, 1'b0},
             '{8'h66, 8'h02, 8'h02, 8'h19, 4'h2, 9'h07C, 4'h7, 1'b1},
             '{8'h23, 8'h23, 8'h23, 8'h19, 4'h6, 9'h030, 4'h5, 1'b0},
             '{8'h05, 8'h28, 8'h0F, 8'h19, 4'h2, 9'h040, 4'h5, 1'b0},
             '{8'h14, 8'h14, 8'h14, 8'h6E, 4'h2, 9'h100, 4'h9, 1'b0},
             '{8'h14, 8'h14, 8'h14, 8'hAA, 4'h2, 9'h18C, 4'hB, 1'b1},
             '{8'h14, 8'h14, 8'h14, 8'h82, 4'hA, 9'h180, 4'h9, 1'b0}};
    cyc(4);
    rst_i = 1'b0;
    wr_oc(8'hFF, 10'h064);
    cyc(20);
    foreach (rows[k]) begin
      run_row(rows[k]);
    end
    deg_i[0] = 8'h19;
    cur_i[0] = {8'h10, 8'h10, 8'h12};
    // a stray selector must not reach the channel limit
    wr_oc(8'h01, 10'h00A);
    wr_oc(8'h00, 10'h005);
    cyc(2);
    pulse_clr();
    cyc(3);
    chk(pwm_o[0], 3'h6);
    chk(pwm_oe_n_o[0], 3'h0);
    chk(stat_o[0], 9'h000);
    wr_oc(8'h00, 10'h3FF);
    deg_i[0] = 8'h6E;
    cyc(3);
    deg_i[0] = 8'h19;
    cyc(5);
    chk(stat_o[0][`OFS_ST_OTW], 1'b1);
    chk(host_alert_n_o, 1'b0);
    mask_i[0] = 9'h100;
    cyc(2);
    chk(host_alert_n_o, 1'b1);
    mask_i[0] = 9'h000;
    pulse_clr();
    cyc(2);
    chk(stat_o[0], 9'h000);
    chk(host_alert_n_o, 1'b1);
    $display("limit and mask done");
    rise_i = 8'h00;
    conv_en_i[0] = 1'b0;
    cyc(3);
    pulse_clr();
    conv_en_i[0] = 1'b1;
    cyc(15);
    chk(stat_o[0][`OFS_ST_TON], 1'b0);
    cyc(30);
    chk(stat_o[0][`OFS_ST_TON], 1'b1);
    chk(class_o[0][`OFS_CL_VOUT], 1'b1);
    chk(pwm_oe_n_o[0], 3'h7);
    ign_i[0] = 4'h0;
    conv_en_i[0] = 1'b0;
    cyc(3);
    pulse_clr();
    conv_en_i[0] = 1'b1;
    cyc(5);
    chk(stat_o[0][`OFS_ST_UVF], 1'b1);
    chk(pwm_oe_n_o[0], 3'h7);
    $display("turn-on done");
    ramp_to(13'h05DC, 2'h0, 8'h00, 13'h04B0, 1'b1);
    ramp_to(13'h03E8, 2'h2, 8'h00, 13'h01F4, 1'b1);
    ramp_to(13'h03E8, 2'h1, 8'h00, 13'h04B0, 1'b1);
    ramp_to(13'h04A6, 2'h0, 8'h14, 13'h04B0, 1'b1);
    ramp_to(13'h03E8, 2'h0, 8'h00, 13'h03E8, 1'b0);
    wr_uv(1'b0, 13'h0368);
    chk(uvw_rpt_o[0], 13'h0368);
    wr_uv(1'b1, 13'h02E8);
    chk(uvf_rpt_o[0], 13'h02E8);
    target_cmd_i[0] = 13'h044C;
    cyc(10);
    chk(uvw_rpt_o[0], 13'h03CC);
    chk(uvf_rpt_o[0], 13'h034C);
    wr_uv(1'b1, 13'h0410);
    chk(uvf_rpt_o[0], 13'h042C);
    wr_uv(1'b0, 13'h04B0);
    chk(uvw_rpt_o[0], 13'h0434);
    scale_log2_i[0] = 2'h1;
    wr_uv(1'b0, 13'h034C);
    chk(uvw_rpt_o[0], 13'h03CC);
    $display("undervoltage offsets done");
    rst_i = 1'b1;
    cyc(1);
    chk(pwm_oe_n_o, 6'h3F);
    chk(pwm_o, 6'h00);
    chk(stat_o, 18'h00000);
    chk(host_alert_n_o, 1'b1);
    rst_i = 1'b0;
    cyc(2);
    $display("reset done");
    give_verdict();
  end
endmodule
